// File: shared/endian_pkg.sv
// constants and types shared by the byte-order translation logic
package endian_pkg;

  typedef enum logic [1:0] {
    SIZE_BYTE   = 2'b00,
    SIZE_HALF   = 2'b01,
    SIZE_WORD   = 2'b10,
    SIZE_DOUBLE = 2'b11
  } size_t;

  localparam int ADDR_W    = 32;
  localparam int WORD_W    = 32;
  localparam int DWORD_W   = 64;
  localparam int LANES     = 8;
  localparam int PCI_LANES = 4;
  localparam int LANE_W    = 8;

  // low address bits touched by the 3-bit modifier
  localparam int MOD_W        = 3;
  // address bit that picks the high or low core word on the pci side
  localparam int HALF_SEL_BIT = 2;

  localparam logic [2:0] MOD_BYTE   = 3'h7;
  localparam logic [2:0] MOD_HALF   = 3'h6;
  localparam logic [2:0] MOD_WORD   = 3'h4;
  localparam logic [2:0] MOD_DOUBLE = 3'h0;
  localparam logic [2:0] MOD_NONE   = 3'h0;

  localparam logic [7:0] MASK_BYTE   = 8'h01;
  localparam logic [7:0] MASK_HALF   = 8'h03;
  localparam logic [7:0] MASK_WORD   = 8'h0f;
  localparam logic [7:0] MASK_DOUBLE = 8'hff;

  localparam logic        RESET_CORE_LITTLE = 1'b0;
  localparam logic        RESET_EXC_LITTLE  = 1'b0;
  localparam logic [31:0] RESET_ADDR        = 32'h0000_0000;
  localparam logic [31:0] RESET_WORD        = 32'h0000_0000;
  localparam logic [3:0]  RESET_PCI_EN      = 4'h0;
  localparam logic [7:0]  RESET_MEM_EN      = 8'h00;

endpackage : endian_pkg

// File: verilog/endian_lane_translator.sv
// byte-order translation between core address, local memory and pci
// Behaviour
// R1: big-endian puts the most significant byte at the lowest address.
// R2: true little-endian puts the least significant byte at the lowest address.
// R3: core little-endian mode modifies addresses; stored bytes stay big-endian.
// R4: pci bit 31 is core bit 0 of both words; pci bit 0 is bit 31. The big-endian path instead puts core bit 0 on pci bit 7 and core bit 31 on pci bit 24.
// R5: on exception the exception little-endian bit is copied into the mode bit.
// R6: core mode bits drive a 3-bit modifier on core-generated addresses only.
// R7: bridge in little-endian undoes the modification and reverses byte lanes.
// R8: little-endian: memory holds modified order, pci carries true little-endian.
// R9: one bridge select bit enables its address modifier and lane swapper together.
// R10: software should set core and bridge to the same mode before pci access.
// R11: big-endian core applies no address modification.
// R12: big-endian keeps byte order on pci and leaves bit order unchanged.
// R13: core lanes 0-3 and 4-7 both map to pci lane n modulo 4.
// R14: big-endian: most significant internal byte goes to pci lanes bits 7:0.
// R15: modifier xors low three bits with 7, 6, 4 or 0 by size.
module endian_lane_translator
  import endian_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // core state register port
  input  wire logic        state_write_i,
  input  wire logic        state_little_i,
  input  wire logic        state_exc_little_i,
  input  wire logic        exception_take_i,
  output logic             core_little_endian_bit_o,
  output logic             exception_little_endian_bit_o,
  // core address path
  input  wire logic        core_req_i,
  input  wire logic [31:0] core_ea_i,
  input  wire size_t       core_size_i,
  output logic             core_addr_valid_o,
  output logic [31:0]      core_addr_o,
  // bridge configuration
  input  wire logic        bridge_little_endian_select_i,
  output logic             mode_mismatch_o,
  // bridge transfer between local memory and pci
  input  wire logic        xfer_valid_i,
  input  wire logic        xfer_to_pci_i,
  input  wire logic [31:0] xfer_addr_i,
  input  wire size_t       xfer_size_i,
  input  wire logic [0:31] core_data_high_word_i,
  input  wire logic [0:31] core_data_low_word_i,
  input  wire logic [31:0] pci_ad_i,
  output logic             xfer_done_o,
  output logic [31:0]      pci_addr_o,
  output logic [31:0]      pci_ad_o,
  output logic [3:0]       pci_byte_enable_o,
  output logic [0:31]      core_data_high_word_o,
  output logic [0:31]      core_data_low_word_o,
  output logic [7:0]       mem_lane_enable_o
);

  // size constant for the address modifier, zero when big-endian
  function automatic logic [2:0] modifier(input size_t sz, input logic little);
    logic [2:0] m;
    m = MOD_NONE;
    case (sz)
      SIZE_BYTE:   m = MOD_BYTE;
      SIZE_HALF:   m = MOD_HALF;
      SIZE_WORD:   m = MOD_WORD;
      SIZE_DOUBLE: m = MOD_DOUBLE;
      default:     m = MOD_NONE;
    endcase
    modifier = little ? m : MOD_NONE; // see R11
  endfunction : modifier

  // xor is its own inverse, so the same function modifies and unmodifies
  function automatic logic [31:0] munge(input logic [31:0] a, input size_t sz,
                                        input logic little);
    munge = {a[ADDR_W-1:MOD_W], a[MOD_W-1:0] ^ modifier(sz, little)}; // see R15
  endfunction : munge

  // memory lanes touched by an access, bit n for lane n
  function automatic logic [7:0] lane_mask(input logic [2:0] a, input size_t sz);
    logic [7:0] base;
    base = MASK_BYTE;
    case (sz)
      SIZE_BYTE:   base = MASK_BYTE;
      SIZE_HALF:   base = MASK_HALF;
      SIZE_WORD:   base = MASK_WORD;
      SIZE_DOUBLE: base = MASK_DOUBLE;
      default:     base = MASK_BYTE;
    endcase
    lane_mask = 8'(base << a);
  endfunction : lane_mask

  // lane n trades places with lane 7-n
  function automatic logic [0:63] swap_lanes(input logic [0:63] d);
    logic [0:63] r;
    r = d;
    for (int n = 0; n < LANES; n++) begin
      r[LANE_W*n +: LANE_W] = d[LANE_W*(LANES-1-n) +: LANE_W];
    end
    swap_lanes = r;
  endfunction : swap_lanes

  function automatic logic [7:0] swap_mask(input logic [7:0] m);
    logic [7:0] r;
    r = m;
    for (int n = 0; n < LANES; n++) begin
      r[n] = m[LANES-1-n];
    end
    swap_mask = r;
  endfunction : swap_mask

  // core state bits
  logic core_little_q;
  logic exc_little_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      core_little_q <= RESET_CORE_LITTLE;
      exc_little_q  <= RESET_EXC_LITTLE;
    end else begin
      if (exception_take_i) begin
        core_little_q <= exc_little_q; // see R5
      end else if (state_write_i) begin
        core_little_q <= state_little_i;
      end
      if (state_write_i) begin
        exc_little_q <= state_exc_little_i;
      end
    end
  end

  assign core_little_endian_bit_o      = core_little_q;
  assign exception_little_endian_bit_o = exc_little_q;

  // core address modifier, touches only addresses the core generates
  logic [31:0] core_addr_d;
  logic [31:0] core_addr_q;
  logic        core_valid_q;

  assign core_addr_d = munge(core_ea_i, core_size_i, core_little_q); // see R3 see R6

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      core_addr_q  <= RESET_ADDR;
      core_valid_q <= 1'b0;
    end else begin
      core_valid_q <= core_req_i;
      if (core_req_i) begin
        core_addr_q <= core_addr_d;
      end
    end
  end

  assign core_addr_valid_o = core_valid_q;
  assign core_addr_o       = core_addr_q;

  // bridge: one select bit drives both the unmodifier and the swapper
  wire         bridge_little = bridge_little_endian_select_i;
  wire  [31:0] pci_addr_d    = munge(xfer_addr_i, xfer_size_i, bridge_little); // see R7 see R9
  wire         half_sel      = pci_addr_d[HALF_SEL_BIT];
  wire  [0:63] mem_dword     = {core_data_high_word_i, core_data_low_word_i};
  wire  [0:63] out_dword     = bridge_little ? swap_lanes(mem_dword) : mem_dword; // see R8
  wire  [7:0]  mem_mask      = lane_mask(xfer_addr_i[MOD_W-1:0], xfer_size_i);
  wire  [7:0]  out_mask      = bridge_little ? swap_mask(mem_mask) : mem_mask; // see R2
  wire  [3:0]  pci_en_d      = half_sel ? out_mask[LANES-1:PCI_LANES]
                                        : out_mask[PCI_LANES-1:0]; // see R13
  logic [31:0] pci_word_d;
  logic [0:63] rep_dword;
  wire  [0:63] in_dword      = bridge_little ? swap_lanes(rep_dword) : rep_dword; // see R7

  // core byte n, after any lane swap, goes to pci lane n mod 4; byte msb stays msb
  for (genvar k = 0; k < PCI_LANES; k++) begin : g_to_pci
    assign pci_word_d[LANE_W*k +: LANE_W] = half_sel
      ? out_dword[WORD_W + LANE_W*k +: LANE_W]
      : out_dword[LANE_W*k +: LANE_W]; // see R4 see R12 see R14
  end

  // pci word lands in both core words; lane enables pick the live half
  for (genvar n = 0; n < LANES; n++) begin : g_from_pci
    assign rep_dword[LANE_W*n +: LANE_W] =
      pci_ad_i[LANE_W*(n % PCI_LANES) +: LANE_W]; // see R13
  end

  logic [31:0] pci_addr_q;
  logic [31:0] pci_ad_q;
  logic [3:0]  pci_en_q;
  logic [0:31] mem_high_q;
  logic [0:31] mem_low_q;
  logic [7:0]  mem_en_q;
  logic        done_q;
  logic        mismatch_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pci_addr_q <= RESET_ADDR;
      pci_en_q   <= RESET_PCI_EN;
      mem_en_q   <= RESET_MEM_EN;
      done_q     <= 1'b0;
    end else begin
      done_q <= xfer_valid_i;
      if (xfer_valid_i) begin
        pci_addr_q <= pci_addr_d;
        pci_en_q   <= pci_en_d;
        mem_en_q   <= mem_mask;
      end
    end
  end

  // data words reset too, so read outputs show zero until the first read transfer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pci_ad_q   <= RESET_WORD;
      mem_high_q <= RESET_WORD;
      mem_low_q  <= RESET_WORD;
    end else if (xfer_valid_i && xfer_to_pci_i) begin
      pci_ad_q <= pci_word_d;
    end else if (xfer_valid_i) begin
      mem_high_q <= in_dword[0:WORD_W-1];
      mem_low_q  <= in_dword[WORD_W:DWORD_W-1];
    end
  end

  // software is meant to keep both modes equal; flag it when not
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mismatch_q <= 1'b0;
    end else begin
      mismatch_q <= core_little_q != bridge_little; // see R10
    end
  end

  assign xfer_done_o           = done_q;
  assign pci_addr_o            = pci_addr_q;
  assign pci_ad_o              = pci_ad_q;
  assign pci_byte_enable_o     = pci_en_q;
  assign core_data_high_word_o = mem_high_q;
  assign core_data_low_word_o  = mem_low_q;
  assign mem_lane_enable_o     = mem_en_q;
  assign mode_mismatch_o       = mismatch_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  exception_copy_a: assert property ( // see R5
    exception_take_i |=> core_little_endian_bit_o == $past(exc_little_q))
    else $error("exception did not copy mode bit");

  big_no_modify_a: assert property ( // see R11
    core_req_i && !core_little_q |=> core_addr_o == $past(core_ea_i))
    else $error("big-endian core address modified");

  core_modify_a: assert property ( // see R6
    core_req_i && core_little_q && core_size_i == SIZE_BYTE
    |=> core_addr_o[2:0] == ($past(core_ea_i[2:0]) ^ MOD_BYTE))
    else $error("core byte address not modified");

  word_modify_a: assert property ( // see R15
    core_req_i && core_little_q && core_size_i == SIZE_WORD
    ##1 core_addr_valid_o |-> core_addr_o[2:0] == ($past(core_ea_i[2:0]) ^ MOD_WORD))
    else $error("core word address not modified");

  bridge_unmodify_a: assert property ( // see R9
    xfer_valid_i && bridge_little_endian_select_i && xfer_size_i == SIZE_HALF
    |=> xfer_done_o && pci_addr_o[2:0] == ($past(xfer_addr_i[2:0]) ^ MOD_HALF))
    else $error("bridge address not unmodified");

  big_high_lane_a: assert property ( // see R14
    xfer_valid_i && xfer_to_pci_i && !bridge_little_endian_select_i && !xfer_addr_i[2]
    |=> pci_ad_o[7:0] == $past(core_data_high_word_i[0:7]))
    else $error("high word lane 0 misplaced");

  big_low_lane_a: assert property ( // see R13
    xfer_valid_i && xfer_to_pci_i && !bridge_little_endian_select_i && xfer_addr_i[2]
    |=> pci_ad_o[31:24] == $past(core_data_low_word_i[24:31]))
    else $error("low word lane 3 misplaced");

  read_bit_order_a: assert property ( // see R4
    xfer_valid_i && !xfer_to_pci_i && !bridge_little_endian_select_i
    |=> core_data_high_word_o[0:7] == $past(pci_ad_i[7:0])
        && core_data_low_word_o[24:31] == $past(pci_ad_i[31:24]))
    else $error("pci read bit order wrong");

  little_swap_a: assert property ( // see R7
    xfer_valid_i && xfer_to_pci_i && bridge_little_endian_select_i
    && xfer_size_i == SIZE_BYTE && xfer_addr_i[2:0] == 3'h7
    |=> pci_ad_o[7:0] == $past(core_data_low_word_i[24:31]) && pci_byte_enable_o == 4'h1)
    else $error("little-endian byte not swapped");

  big_first_byte_a: assert property ( // see R1
    xfer_valid_i && !bridge_little_endian_select_i && xfer_size_i == SIZE_WORD
    && xfer_addr_i[2:0] == 3'h0 |=> pci_byte_enable_o == 4'hf && pci_addr_o[1:0] == 2'h0)
    else $error("big-endian word enables wrong");

  true_little_lane_a: assert property ( // see R8
    xfer_valid_i && bridge_little_endian_select_i && xfer_size_i == SIZE_BYTE
    |=> pci_byte_enable_o == 4'(4'h1 << pci_addr_o[1:0]))
    else $error("pci byte not in true little-endian lane");

  done_pulse_a: assert property (
    xfer_valid_i |=> xfer_done_o)
    else $error("transfer not answered");

endmodule : endian_lane_translator

// File: tb/pci_agent_model.sv
// far-side pci agent: supplies read words and keeps the last write seen
module pci_agent_model
  import endian_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        xfer_done_i,
  input  wire logic [31:0] pci_ad_wr_i,
  input  wire logic [31:0] rd_word_i,
  output logic [31:0]      pci_ad_o,
  output logic [31:0]      last_wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // read data is true little-endian: lane 0 is bits 7:0
  assign pci_ad_o = rd_word_i;
  // captured at the done pulse, when the write data is settled
  always_ff @(posedge clock_i) begin
    if (xfer_done_i) begin
      last_wr_o <= pci_ad_wr_i;
    end
  end
endmodule : pci_agent_model

// File: tb/tb_top.sv
// self-checking bench for the byte-order translator
module tb_top
  import endian_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_n_i, sw, sl, sel_, et, creq, sel, xv, xtp, mm, av, xd, ml, me;
  logic [31:0] cea, ca, xa, pad, pa, po, rd, lw;
  logic [0:31] hi, lo, ho, loo;
  logic [3:0]  be;
  logic [7:0]  mle;
  size_t       csz, xsz;
  int err_count = 0;
  int num_checks = 0;

  endian_lane_translator DUT (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .state_write_i(sw), .state_little_i(sl),
    .state_exc_little_i(sel_), .exception_take_i(et), .core_little_endian_bit_o(ml),
    .exception_little_endian_bit_o(me), .core_req_i(creq), .core_ea_i(cea),
    .core_size_i(csz), .core_addr_valid_o(av), .core_addr_o(ca),
    .bridge_little_endian_select_i(sel), .mode_mismatch_o(mm), .xfer_valid_i(xv),
    .xfer_to_pci_i(xtp), .xfer_addr_i(xa), .xfer_size_i(xsz),
    .core_data_high_word_i(hi), .core_data_low_word_i(lo), .pci_ad_i(pad),
    .xfer_done_o(xd), .pci_addr_o(pa), .pci_ad_o(po), .pci_byte_enable_o(be),
    .core_data_high_word_o(ho), .core_data_low_word_o(loo), .mem_lane_enable_o(mle));

  pci_agent_model PEER (.clock_i(clock_i), .xfer_done_i(xd), .pci_ad_wr_i(po),
    .rd_word_i(rd), .pci_ad_o(pad), .last_wr_o(lw));

  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic set_mode(input logic w, input logic l, input logic e, input logic x);
    @(negedge clock_i);
    sw = w; sl = l; sel_ = e; et = x;
    @(negedge clock_i);
    sw = 1'b0; et = 1'b0;
  endtask : set_mode

  task automatic core_acc(input logic [31:0] ea, input size_t s, input logic [31:0] exp);
    @(negedge clock_i);
    creq = 1'b1; cea = ea; csz = s;
    @(negedge clock_i);
    creq = 1'b0;
    chk("addr_valid", 32'h1, {31'h0, av});
    chk("core_addr", exp, ca);
  endtask : core_acc

  task automatic xfer(input logic tp, input logic [31:0] a, input size_t s);
    @(negedge clock_i);
    xv = 1'b1; xtp = tp; xa = a; xsz = s;
    @(negedge clock_i);
    xv = 1'b0;
    chk("xfer_done", 32'h1, {31'h0, xd});
  endtask : xfer

  // mode bits, exception copy and exception-over-write priority
  task automatic t_mode();
    set_mode(1'b1, 1'b0, 1'b1, 1'b0);
    chk("exc_bit", 32'h1, {31'h0, me});
    set_mode(1'b0, 1'b0, 1'b0, 1'b1);
    chk("mode_after_exc", 32'h1, {31'h0, ml});
    set_mode(1'b1, 1'b0, 1'b0, 1'b1);
    chk("exc_wins", 32'h1, {31'h0, ml});
    chk("exc_bit_written", 32'h0, {31'h0, me});
    @(negedge clock_i);
    chk("mismatch", 32'h1, {31'h0, mm});
  endtask : t_mode

  // core modifier per size in both modes, with an idle cycle between accesses
  task automatic t_core();
    logic [2:0] k [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    for (int i = 0; i < 4; i++) begin
      core_acc(32'h100, size_t'(i), 32'h100 ^ {29'h0, k[i]});
    end
    set_mode(1'b1, 1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      core_acc(32'h105, size_t'(i), 32'h105);
    end
  endtask : t_core

  // big-endian lanes, both core words
  task automatic t_be();
    sel = 1'b0;
    hi = 32'h00112233;
    lo = 32'h44556677;
    xfer(1'b1, 32'h0, SIZE_WORD);
    chk("be_ad_high", 32'h33221100, po);
    chk("be_en", 32'hf, {28'h0, be});
    chk("be_mem_en", 32'h0f, {24'h0, mle});
    xfer(1'b1, 32'h4, SIZE_WORD);
    chk("be_ad_low", 32'h77665544, po);
    chk("be_pci_addr", 32'h4, pa);
    chk("peer_wr", 32'h33221100, lw);
    rd = 32'h44332211;
    xfer(1'b0, 32'h0, SIZE_WORD);
    chk("be_rd_high", 32'h11223344, ho);
    chk("be_rd_low", 32'h11223344, loo);
  endtask : t_be

  // little-endian bridge: unmodified address, reversed lanes
  task automatic t_le();
    sel = 1'b1;
    xfer(1'b1, 32'h4, SIZE_WORD);
    chk("le_pci_addr", 32'h0, pa);
    chk("le_ad", 32'h44556677, po);
    chk("le_mem_en", 32'hf0, {24'h0, mle});
    xfer(1'b1, 32'h7, SIZE_BYTE);
    chk("le_byte_addr", 32'h0, pa);
    // memory lane 7 holds the byte, true little-endian puts it on lane 0
    chk("le_byte_ad", 32'h00000077, po & 32'hff);
    chk("le_byte_en", 32'h1, {28'h0, be});
    // munged halfword at 2 is the true halfword at 4, low byte on lane 0
    xfer(1'b1, 32'h2, SIZE_HALF);
    chk("le_half_addr", 32'h4, pa);
    chk("le_half_ad", 32'h00002233, po & 32'hffff);
    chk("le_half_en", 32'h3, {28'h0, be});
    chk("le_half_mem_en", 32'h0c, {24'h0, mle});
    xfer(1'b0, 32'h4, SIZE_WORD);
    chk("le_rd_high", 32'h44332211, ho);
    chk("le_rd_low", 32'h44332211, loo);
  endtask : t_le

  initial begin
    rst_n_i = 1'b0; sw = 1'b0; sl = 1'b0; sel_ = 1'b0; et = 1'b0; creq = 1'b0;
    cea = '0; csz = SIZE_BYTE; sel = 1'b0; xv = 1'b0; xtp = 1'b0; xa = '0;
    xsz = SIZE_BYTE; hi = '0; lo = '0; rd = '0;
    repeat (2) @(negedge clock_i);
    rst_n_i = 1'b1;
    chk("reset_mode", 32'h0, {31'h0, ml});
    t_mode();
    t_core();
    t_be();
    t_le();
    final_report();
  end

  // far beyond the roughly 41 cycles the scenarios need
  initial begin
    #100us;
    err_count++;
    final_report();
  end
endmodule : tb_top
